/* sirc_pkg.sv */
// constants, state types and helpers shared by the infrared pulse codec
package sirc_pkg;

  localparam int          SIRC_FIFO_DEPTH  = 16;
  localparam int          SIRC_BYTE_W      = 8;

  localparam logic [3:0]  SIRC_CNT_RST     = 4'h0;
  localparam logic [3:0]  SIRC_TX_ON       = 4'h7;
  localparam logic [3:0]  SIRC_TX_OFF      = 4'ha;
  localparam logic [3:0]  SIRC_CELL_LAST   = 4'hf;
  localparam logic [3:0]  SIRC_STROBE_CNT  = 4'h7;
  localparam logic [3:0]  SIRC_BIT_START   = 4'h0;
  localparam logic [3:0]  SIRC_BIT_STOP    = 4'h9;
  localparam logic [7:0]  SIRC_BYTE_RST    = 8'h00;

  typedef enum logic [1:0] {
    SIRC_DEC_IDLE = 2'b01,
    SIRC_DEC_LOW  = 2'b10
  } sirc_dec_t;

  typedef enum logic [2:0] {
    SIRC_SMP_IDLE = 3'b001,
    SIRC_SMP_RUN  = 3'b010,
    SIRC_SMP_HOLD = 3'b100
  } sirc_smp_t;

  function automatic logic [3:0] sirc_inc4(input logic [3:0] v);
    sirc_inc4 = v + 4'h1;
  endfunction : sirc_inc4

endpackage : sirc_pkg

/* sirc_fifo_if.sv */
// valid/ready carrier between the frame sampler and the byte fifo
`timescale 1ns/10ps
interface sirc_fifo_if #(
  parameter int W = 8
);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;

  modport fifo (
    input  in_valid,
    input  in_data,
    input  out_ready,
    output in_ready,
    output out_valid,
    output out_data
  );

  modport user (
    output in_valid,
    output in_data,
    output out_ready,
    input  in_ready,
    input  out_valid,
    input  out_data
  );
endinterface : sirc_fifo_if

/* sirc_fifo.sv */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/10ps
module sirc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input wire logic   sys_clk,
  input wire logic   rst_b,
  sirc_fifo_if.fifo  port_if
);
  import sirc_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_reg [DEPTH];
  logic [W-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [AW:0]   count_reg, count_next;
  logic          push;
  logic          pop;

  assign port_if.in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign port_if.out_valid = (count_reg != '0);
  assign port_if.out_data  = mem_reg[rd_ptr_reg];

  always_comb begin
    push        = port_if.in_valid && port_if.in_ready;
    pop         = port_if.out_valid && port_if.out_ready;
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = port_if.in_data;
      wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
    end
    if (pop) begin
      rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
    end
    if (push && !pop) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
    mem_reg <= mem_next;
  end

  a_fifo_full_block: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (count_reg == (AW+1)'(DEPTH)) |-> !port_if.in_ready)
    else $error("fifo accepts data while full");

endmodule : sirc_fifo

/* sirc_codec.sv */
// infrared pulse encoder/decoder between a uart and an optical transceiver
//
// Contract
// - 16-sample bit cell; zero is one pulse
// - start, data, stop bits coded alike
// - lowest-rate protocol; slower matching rates work
// - zero pulse three sample clocks long
// - idle high input holds output low, counter cleared
// - pulse rises at seventh sample falling edge
// - pulse falls at tenth, three clocks wide
// - pulse repeats every cell while input low
// - reset drives receive output high, counter cleared
// - falling edge drives output low next rise
// - output low sixteen sample clocks then high
// - no falling edges keeps output high
// - either pulse polarity decoded on falling edge
// - late edge may give one-clock high glitch
// - reset initialises both encode and decode
`timescale 1ns/10ps
module sirc_codec #(
  parameter int BYTE_W     = sirc_pkg::SIRC_BYTE_W,
  parameter int FIFO_DEPTH = sirc_pkg::SIRC_FIFO_DEPTH
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              sample_clock_16x,
  input  wire logic              uart_tx_in,
  output logic                   ir_tx_out,
  input  wire logic              ir_rx_in,
  output logic                   uart_rx_out,
  output logic                   rx_byte_valid,
  output logic [BYTE_W-1:0]      rx_byte_data,
  input  wire logic              rx_byte_ready,
  output logic                   rx_frame_err,
  output logic                   rx_overrun
);
  import sirc_pkg::*;

  // sample clock edges, seen in the system clock
  logic samp_prev_reg, samp_prev_next;
  logic s_rise;
  logic s_fall;

  assign s_rise = sample_clock_16x && !samp_prev_reg;
  assign s_fall = !sample_clock_16x && samp_prev_reg;

  always_comb begin
    samp_prev_next = sample_clock_16x;
  end

  // not reset: tracks the pin so no false edge follows reset
  always_ff @(posedge sys_clk) begin
    samp_prev_reg <= samp_prev_next;
  end

  // encoder
  logic [3:0] tx_cnt_reg, tx_cnt_next;
  logic       tx_out_reg, tx_out_next;

  always_comb begin
    tx_cnt_next = tx_cnt_reg;
    tx_out_next = tx_out_reg;
    if (uart_tx_in) begin
      tx_cnt_next = SIRC_CNT_RST;
      tx_out_next = 1'b0;
    end else if (s_fall) begin
      tx_cnt_next = sirc_inc4(tx_cnt_reg);
      if (tx_cnt_next == SIRC_TX_ON) begin
        tx_out_next = 1'b1;
      end else if (tx_cnt_next == SIRC_TX_OFF) begin
        tx_out_next = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_cnt_reg <= SIRC_CNT_RST;
      tx_out_reg <= 1'b0;
    end else begin
      tx_cnt_reg <= tx_cnt_next;
      tx_out_reg <= tx_out_next;
    end
  end

  assign ir_tx_out = tx_out_reg;

  // receive input synchroniser and falling-edge detect
  logic ir_s1_reg, ir_s2_reg, ir_s3_reg;
  logic ir_fall;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ir_s1_reg <= 1'b1;
      ir_s2_reg <= 1'b1;
      ir_s3_reg <= 1'b1;
    end else begin
      ir_s1_reg <= ir_rx_in;
      ir_s2_reg <= ir_s1_reg;
      ir_s3_reg <= ir_s2_reg;
    end
  end

  assign ir_fall = ir_s3_reg && !ir_s2_reg;

  // decoder
  sirc_dec_t  dec_state_reg, dec_state_next;
  logic [3:0] rx_cnt_reg, rx_cnt_next;
  logic       rx_pend_reg, rx_pend_next;
  logic       rx_out_reg, rx_out_next;

  always_comb begin
    dec_state_next = dec_state_reg;
    rx_cnt_next    = rx_cnt_reg;
    rx_out_next    = rx_out_reg;
    rx_pend_next   = rx_pend_reg;
    if (s_rise) begin
      if (rx_pend_reg) begin
        dec_state_next = SIRC_DEC_LOW;
        rx_cnt_next    = SIRC_CNT_RST;
        rx_out_next    = 1'b0;
        rx_pend_next   = 1'b0;
      end else begin
        case (dec_state_reg)
          SIRC_DEC_LOW: begin
            if (rx_cnt_reg == SIRC_CELL_LAST) begin
              dec_state_next = SIRC_DEC_IDLE;
              rx_cnt_next    = SIRC_CNT_RST;
              rx_out_next    = 1'b1;
            end else begin
              rx_cnt_next = sirc_inc4(rx_cnt_reg);
            end
          end
          SIRC_DEC_IDLE: begin
            rx_out_next = 1'b1;
          end
          default: begin
            dec_state_next = SIRC_DEC_IDLE;
            rx_out_next    = 1'b1;
          end
        endcase
      end
    end
    if (ir_fall) begin
      rx_pend_next = 1'b1; // edge wins over the take
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      dec_state_reg <= SIRC_DEC_IDLE;
      rx_cnt_reg    <= SIRC_CNT_RST;
      rx_pend_reg   <= 1'b0;
      rx_out_reg    <= 1'b1;
    end else begin
      dec_state_reg <= dec_state_next;
      rx_cnt_reg    <= rx_cnt_next;
      rx_pend_reg   <= rx_pend_next;
      rx_out_reg    <= rx_out_next;
    end
  end

  assign uart_rx_out = rx_out_reg;

  // frame sampler: strobes mid-cell, assembles bytes lsb first
  sirc_fifo_if #(.W(BYTE_W)) q_if ();

  sirc_smp_t         smp_state_reg, smp_state_next;
  logic [3:0]        smp_cnt_reg, smp_cnt_next;
  logic [3:0]        smp_bit_reg, smp_bit_next;
  logic [BYTE_W-1:0] smp_byte_reg, smp_byte_next;
  logic              ferr_reg, ferr_next;
  logic              ovr_reg, ovr_next;
  logic              rx_out_fall;

  assign rx_out_fall = !rx_out_next && rx_out_reg && s_rise;

  always_comb begin
    smp_state_next = smp_state_reg;
    smp_cnt_next   = smp_cnt_reg;
    smp_bit_next   = smp_bit_reg;
    smp_byte_next  = smp_byte_reg;
    ferr_next      = 1'b0;
    ovr_next       = 1'b0;
    case (smp_state_reg)
      SIRC_SMP_IDLE: begin
        if (rx_out_fall) begin
          smp_state_next = SIRC_SMP_RUN;
          smp_cnt_next   = SIRC_CNT_RST;
          smp_bit_next   = SIRC_BIT_START;
        end
      end
      SIRC_SMP_RUN: begin
        if (s_rise) begin
          smp_cnt_next = sirc_inc4(smp_cnt_reg);
          if (smp_cnt_reg == SIRC_STROBE_CNT) begin
            smp_bit_next = sirc_inc4(smp_bit_reg);
            if (smp_bit_reg == SIRC_BIT_START) begin
              if (uart_rx_out) begin
                smp_state_next = SIRC_SMP_IDLE; // false start
              end
            end else if (smp_bit_reg == SIRC_BIT_STOP) begin
              if (uart_rx_out) begin
                smp_state_next = SIRC_SMP_HOLD;
              end else begin
                smp_state_next = SIRC_SMP_IDLE;
                ferr_next      = 1'b1;
              end
            end else begin
              smp_byte_next = {uart_rx_out, smp_byte_reg[BYTE_W-1:1]};
            end
          end
        end
      end
      SIRC_SMP_HOLD: begin
        if (q_if.in_ready) begin
          smp_state_next = SIRC_SMP_IDLE;
        end else if (rx_out_fall) begin
          ovr_next = 1'b1; // frame lost while fifo stalls
        end
      end
      default: begin
        smp_state_next = SIRC_SMP_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      smp_state_reg <= SIRC_SMP_IDLE;
      smp_cnt_reg   <= SIRC_CNT_RST;
      smp_bit_reg   <= SIRC_BIT_START;
      smp_byte_reg  <= BYTE_W'(SIRC_BYTE_RST);
      ferr_reg      <= 1'b0;
      ovr_reg       <= 1'b0;
    end else begin
      smp_state_reg <= smp_state_next;
      smp_cnt_reg   <= smp_cnt_next;
      smp_bit_reg   <= smp_bit_next;
      smp_byte_reg  <= smp_byte_next;
      ferr_reg      <= ferr_next;
      ovr_reg       <= ovr_next;
    end
  end

  assign q_if.in_valid  = (smp_state_reg == SIRC_SMP_HOLD);
  assign q_if.in_data   = smp_byte_reg;
  assign q_if.out_ready = rx_byte_ready;
  assign rx_byte_valid  = q_if.out_valid;
  assign rx_byte_data   = q_if.out_data;
  assign rx_frame_err   = ferr_reg;
  assign rx_overrun     = ovr_reg;

  sirc_fifo #(
    .W     (BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .port_if (q_if)
  );

  a_tx_idle_low: assert property (@(posedge sys_clk) disable iff (!rst_b)
    uart_tx_in |=> (!ir_tx_out && tx_cnt_reg == SIRC_CNT_RST))
    else $error("transmit pulse while uart line idle");

  a_tx_rise_seven: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(ir_tx_out) |-> (tx_cnt_reg == SIRC_TX_ON && $past(s_fall)))
    else $error("transmit pulse rose at wrong sample edge");

  a_tx_fall_ten: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ($fell(ir_tx_out) && !$past(uart_tx_in)) |-> (tx_cnt_reg == SIRC_TX_OFF))
    else $error("transmit pulse fell at wrong sample edge");

  a_tx_cell_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (s_fall && !uart_tx_in && tx_cnt_reg == SIRC_CELL_LAST)
      |=> (tx_cnt_reg == SIRC_CNT_RST))
    else $error("transmit bit cell not sixteen samples");

  a_rx_reset_state: assert property (@(posedge sys_clk)
    !rst_b |=> (uart_rx_out && rx_cnt_reg == SIRC_CNT_RST))
    else $error("decoder not cleared by reset");

  a_rx_edge_take: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (rx_pend_reg && s_rise) |=> !uart_rx_out)
    else $error("receive output not driven low after edge");

  a_rx_low_len: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(uart_rx_out) |-> ($past(rx_cnt_reg) == SIRC_CELL_LAST))
    else $error("receive low period not sixteen samples");

  a_rx_quiet_high: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (dec_state_reg == SIRC_DEC_IDLE && !rx_pend_reg) |-> uart_rx_out)
    else $error("receive output low without an edge");

  a_rx_edge_seen: assert property (@(posedge sys_clk) disable iff (!rst_b)
    ir_fall |=> rx_pend_reg)
    else $error("receive falling edge lost");

endmodule : sirc_codec

/* sirc_far_model.sv */
// optical far end: one pulse per zero bit, either pulse polarity
`timescale 1ns/10ps
module sirc_far_model #(
  parameter int CELL  = 448,
  parameter int PULSE = 84
) (
  input  wire logic sys_clk,
  output logic      ir_rx_in
);
  logic idle = 1'b1;

  initial ir_rx_in = 1'b1;

  // positive pulses idle low, negative pulses idle high
  task automatic set_pol(input logic pos);
    @(negedge sys_clk);
    idle = !pos;
    ir_rx_in = idle;
  endtask : set_pol

  // lsb first, cell of fixed length, pulse three samples wide
  task automatic send(input logic [9:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      if (!bits[i]) begin
        @(negedge sys_clk);
        ir_rx_in = !idle;
        repeat (PULSE) @(negedge sys_clk);
        ir_rx_in = idle;
        repeat (CELL - PULSE - 1) @(negedge sys_clk);
      end else begin
        repeat (CELL) @(negedge sys_clk);
      end
    end
  endtask : send
endmodule : sirc_far_model

/* tb_top.sv */
// self-checking bench for the infrared pulse codec
`timescale 1ns/10ps
module tb_top;
  import sirc_pkg::*;
  localparam int H  = 14;
  localparam int SP = 2 * H;
  logic       sys_clk          = 1'b0;
  logic       rst_b            = 1'b0;
  logic       sample_clock_16x = 1'b0;
  logic       uart_tx_in       = 1'b1;
  logic       rx_byte_ready    = 1'b0;
  logic       ovr_seen         = 1'b0;
  logic       ferr_seen        = 1'b0;
  logic       ir_tx_out, ir_rx_in, uart_rx_out, rx_byte_valid, rx_frame_err, rx_overrun;
  logic [7:0] rx_byte_data;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         div = 0;
  int         n_sfall = 0;

  sirc_codec sirc_codec_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .sample_clock_16x(sample_clock_16x),
    .uart_tx_in(uart_tx_in), .ir_tx_out(ir_tx_out), .ir_rx_in(ir_rx_in),
    .uart_rx_out(uart_rx_out), .rx_byte_valid(rx_byte_valid), .rx_byte_data(rx_byte_data),
    .rx_byte_ready(rx_byte_ready), .rx_frame_err(rx_frame_err), .rx_overrun(rx_overrun)
  );

  sirc_far_model #(.CELL(16 * SP), .PULSE(3 * SP)) sirc_far_model_i (
    .sys_clk(sys_clk), .ir_rx_in(ir_rx_in)
  );

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  // sample clock below the top rate, same at both ends
  always @(negedge sys_clk) begin
    div <= (div == H - 1) ? 0 : div + 1;
    if (div == H - 1) begin
      sample_clock_16x <= !sample_clock_16x;
      if (sample_clock_16x) n_sfall <= n_sfall + 1;
    end
  end

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (rx_overrun === 1'b1) ovr_seen <= 1'b1;
    if (rx_frame_err === 1'b1) ferr_seen <= 1'b1;
    if (cyc == 99000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_for(input logic rx, input logic v, output int c);
    for (int k = 0; k < 600 && (rx ? uart_rx_out : ir_tx_out) !== v; k++) @(negedge sys_clk);
    c = cyc;
  endtask : wait_for

  task automatic hold(input logic rx, input logic v, input int n);
    logic ok = 1'b1;
    repeat (n) begin
      @(negedge sys_clk);
      if ((rx ? uart_rx_out : ir_tx_out) !== v) ok = 1'b0;
    end
    check(ok, 1'b1);
  endtask : hold

  task automatic t_reset;
    rst_b = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(ir_tx_out, 1'b0);
    check(uart_rx_out, 1'b1);
    check(rx_byte_valid, 1'b0);
    rst_b = 1'b1;
  endtask : t_reset

  task automatic t_encoder;
    int f0, r1, d1, r2;
    while (div != 5) @(negedge sys_clk);
    f0 = n_sfall;
    uart_tx_in = 1'b0;
    wait_for(1'b0, 1'b1, r1);
    check(n_sfall - f0, 7);
    wait_for(1'b0, 1'b0, d1);
    check(n_sfall - f0, 10);
    check(d1 - r1, 3 * SP);
    wait_for(1'b0, 1'b1, r2);
    check(r2 - r1, 16 * SP);
    repeat (SP) @(negedge sys_clk);
    uart_tx_in = 1'b1;
    repeat (2) @(negedge sys_clk);
    hold(1'b0, 1'b0, 16 * SP);
  endtask : t_encoder

  task automatic t_decoder;
    int t0, t1, t2;
    fork
      sirc_far_model_i.send(10'h3fe, 10);
      begin
        t0 = cyc;
        wait_for(1'b1, 1'b0, t1);
        check(t1 - t0 <= SP + 8, 1'b1);
        wait_for(1'b1, 1'b1, t2);
        check(t2 - t1, 16 * SP);
        hold(1'b1, 1'b1, 8 * SP);
      end
    join
  endtask : t_decoder

  task automatic t_fifo;
    logic [7:0] exp [17];
    check({rx_byte_valid, rx_byte_data}, {1'b1, 8'hff});
    rx_byte_ready = 1'b1;
    repeat (3) @(negedge sys_clk);
    rx_byte_ready = 1'b0;
    for (int i = 0; i < 17; i++) begin
      exp[i] = 8'(i * 29 + 3);
      sirc_far_model_i.send({1'b1, exp[i], 1'b0}, 10);
    end
    sirc_far_model_i.send(10'h3fe, 1);
    check(ovr_seen, 1'b1);
    rx_byte_ready = 1'b1;
    for (int i = 0; i < 17; i++) begin
      check({rx_byte_valid, rx_byte_data}, {1'b1, exp[i]});
      @(negedge sys_clk);
    end
    check(rx_byte_valid, 1'b0);
    rx_byte_ready = 1'b0;
  endtask : t_fifo

  task automatic t_frame_err;
    sirc_far_model_i.set_pol(1'b1);
    repeat (11 * 16 * SP) @(negedge sys_clk);
    check(ferr_seen, 1'b0);
    sirc_far_model_i.send({1'b0, 8'h55, 1'b0}, 10);
    check(ferr_seen, 1'b1);
  endtask : t_frame_err

  task automatic print_verdict;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    t_reset();
    t_encoder();
    uart_tx_in = 1'b0;
    repeat (8 * SP) @(negedge sys_clk);
    t_reset();
    uart_tx_in = 1'b1;
    t_decoder();
    t_fifo();
    t_frame_err();
    print_verdict();
  end
endmodule : tb_top
